/* dv/lbi_chk.sv */
`timescale 1ns/100ps
// ==========================
// Bus pin checks
module lbi_chk #(
  parameter int ADDR_W = 30
) (
  input wire logic              core_clk,            // Clock
  input wire logic              nrst,                // Reset
  input wire logic              rsp_valid,           // Done
  input wire logic              proc_phase,          // Phase
  input wire logic [ADDR_W-1:0] word_address,        // Address
  input wire logic [3:0]        byte_lane_en_n,      // Lanes
  input wire logic              addr_valid_strobe_n, // Strobe
  input wire logic              write_read,          // Write
  input wire logic              bus_oe_n,            // Bus drive
  input wire logic              data_lines_oe_n,     // Data drive
  input wire logic              ready_n,             // Completion
  input wire logic              bus_release_grant    // Grant
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_strb;
    $fell(addr_valid_strobe_n) |=> !addr_valid_strobe_n ##1 addr_valid_strobe_n;
  endproperty
  a_strb: assert property (p_strb) else $error("strobe width wrong");
  property p_stab;
    $fell(addr_valid_strobe_n) |=> $stable(word_address) && $stable(byte_lane_en_n);
  endproperty
  a_stab: assert property (p_stab) else $error("address moved in strobe");
  property p_lane; !addr_valid_strobe_n |-> byte_lane_en_n != 4'hF; endproperty
  a_lane: assert property (p_lane) else $error("cycle with no lanes");
  property p_oe; !addr_valid_strobe_n |-> !bus_oe_n && !bus_release_grant; endproperty
  a_oe: assert property (p_oe) else $error("strobe while bus undriven");
  property p_grnt; bus_release_grant |-> bus_oe_n && data_lines_oe_n; endproperty
  a_grnt: assert property (p_grnt) else $error("bus driven in hold");
  property p_wr; !data_lines_oe_n |-> write_read; endproperty
  a_wr: assert property (p_wr) else $error("data driven on read");
  property p_ph; $past(nrst) |-> proc_phase != $past(proc_phase); endproperty
  a_ph: assert property (p_ph) else $error("phase not halving");
  property p_done;
    rsp_valid |-> !$past(ready_n, 3) || !$past(ready_n, 4) || !$past(ready_n, 5);
  endproperty
  a_done: assert property (p_done) else $error("done without completion");
  c_grnt: cover property ($rose(bus_release_grant));
  c_done: cover property (rsp_valid);
  c_wr: cover property ($fell(data_lines_oe_n));
endmodule

bind lbi_local_bus lbi_chk #(.ADDR_W(ADDR_W)) u_chk (.core_clk, .nrst, .rsp_valid, .proc_phase,
  .word_address, .byte_lane_en_n, .addr_valid_strobe_n, .write_read, .bus_oe_n,
  .data_lines_oe_n, .ready_n, .bus_release_grant);

/* dv/lbi_mem_model.sv */
`timescale 1ns/100ps
// ==========================
// Target on the far side of the bus
module lbi_mem_model (
  input  wire logic        core_clk,            // Clock
  input  wire logic        nrst,                // Reset
  input  wire logic [3:0]  wait_cyc,            // Wait cycles
  input  wire logic        half_width_bus_n,    // Narrow target
  input  wire logic [29:0] word_address,        // Address
  input  wire logic [3:0]  byte_lane_en_n,      // Lanes
  input  wire logic        addr_valid_strobe_n, // Strobe
  input  wire logic [3:0]  status,              // Write, mem, data, lock_n
  input  wire logic [31:0] data_lines_out,      // Write data
  input  wire logic        data_lines_oe_n,     // Data drive
  output logic             ready_n,             // Completion
  output logic [31:0]      data_lines_in,       // Read data
  output logic [29:0]      seen_addr,           // Last address
  output logic [3:0]       seen_lanes,          // Last lanes
  output logic [3:0]       seen_st,             // Last status
  output logic [31:0]      seen_wdata,          // Last write data
  output int               strobes              // Cycles seen
);
  logic        pend;
  logic        second;
  logic [3:0]  cnt;
  logic [31:0] word;
  assign word = {word_address[13:0], 2'h1, ~word_address[13:0], 2'h2};
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pend <= 1'b0;
      second <= 1'b0;
      ready_n <= 1'b1;
      strobes <= 0;
      data_lines_in <= 32'h0;
    end else begin
      if (!data_lines_oe_n) seen_wdata <= data_lines_out;
      if (!addr_valid_strobe_n && !pend) begin
        // Lines flip as a cycle opens so stale data is never taken for fresh;
        // held after completion, since the bus side samples them late
        data_lines_in <= ~data_lines_in;
        pend <= 1'b1;
        cnt <= wait_cyc;
        strobes <= strobes + 1;
        seen_addr <= word_address;
        seen_lanes <= byte_lane_en_n;
        seen_st <= status;
      end else if (pend && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pend && !second) begin
        // Completion held a full processor clock, seen at one phase edge
        ready_n <= 1'b0;
        second <= !ready_n;
        if (!half_width_bus_n && byte_lane_en_n[1:0] == 2'h3) begin
          data_lines_in <= {word[15:0], word[31:16]};
        end else begin
          data_lines_in <= word;
        end
      end else if (pend) begin
        ready_n <= 1'b1;
        pend <= 1'b0;
        second <= 1'b0;
      end
    end
  end
endmodule

/* dv/testbench.sv */
`timescale 1ns/100ps
// ==========================
// Local bus scenarios
module testbench;
  import lbi_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_mem = 1'b0;
  logic req_data = 1'b0, req_lock = 1'b0, half_width_bus_n = 1'b1, hold_req = 1'b0, nmi = 1'b0;
  logic maskable_irq = 1'b0, busy_n = 1'b1, error_n = 1'b1, coproc_xfer_request = 1'b0;
  logic next_addr_req_n = 1'b1;
  logic [29:0] req_addr = 30'h0, word_address, seen_addr;
  logic [3:0] req_be = 4'h0, wait_cyc = 4'h0, byte_lane_en_n, seen_lanes, seen_st;
  logic [31:0] req_wdata = 32'h0, rsp_rdata, data_lines_in, data_lines_out, seen_wdata;
  logic req_ready, rsp_valid, int_request, nmi_event, coproc_busy, coproc_fault, coproc_want_xfer;
  logic proc_phase, data_lines_oe_n, addr_valid_strobe_n, write_read, mem_io, data_ctrl, lock_n;
  logic bus_oe_n, ready_n, bus_release_grant;
  int errors = 0, tests_run = 0, strobes;
  always #2.5 core_clk = ~core_clk;
  lbi_local_bus dut (.core_clk, .nrst, .req_valid, .req_ready, .req_addr, .req_be, .req_write,
    .req_mem, .req_data, .req_lock, .req_wdata, .rsp_valid, .rsp_rdata, .int_request, .nmi_event,
    .coproc_busy, .coproc_fault, .coproc_want_xfer, .proc_phase, .data_lines_in, .data_lines_out,
    .data_lines_oe_n, .word_address, .byte_lane_en_n, .addr_valid_strobe_n, .write_read, .mem_io,
    .data_ctrl, .lock_n, .bus_oe_n, .ready_n, .next_addr_req_n, .half_width_bus_n, .hold_req,
    .bus_release_grant, .maskable_irq, .nmi, .busy_n, .error_n, .coproc_xfer_request);
  lbi_mem_model mem (.core_clk, .nrst, .wait_cyc, .half_width_bus_n, .word_address,
    .byte_lane_en_n, .addr_valid_strobe_n, .status({write_read, mem_io, data_ctrl, lock_n}),
    .data_lines_out, .data_lines_oe_n, .ready_n, .data_lines_in, .seen_addr, .seen_lanes,
    .seen_st, .seen_wdata, .strobes);
  function automatic logic [31:0] pat(input logic [29:0] a);
    return {a[13:0], 2'h1, ~a[13:0], 2'h2};
  endfunction
  function automatic logic [31:0] lm(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic xfer(input logic [29:0] a, input logic [3:0] be, input logic [3:0] st);
    int n = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_be <= be;
    {req_write, req_mem, req_data, req_lock} <= st;
    req_wdata <= ~pat(a);
    do @(negedge core_clk); while (req_ready !== 1'b1 && ++n < 200);
    @(posedge core_clk);
    req_valid <= 1'b0;
    do @(negedge core_clk); while (rsp_valid !== 1'b1 && ++n < 400);
    check(32'(n < 400), 32'h1, "no completion");
    check({2'h0, seen_addr}, {2'h0, a}, "address");
    check({28'h0, seen_st}, {28'h0, st ^ 4'h1}, "status");
    if (half_width_bus_n) check({28'h0, seen_lanes}, {28'h0, ~be}, "lanes");
    if (st[3]) check(seen_wdata & lm(be), ~pat(a) & lm(be), "write data");
    else check(rsp_rdata & lm(be), pat(a) & lm(be), "read data");
  endtask
  task automatic t_types();
    logic [3:0] st [6] = '{4'h6, 4'hE, 4'h2, 4'hA, 4'h7, 4'h4};
    for (int i = 0; i < 6; i++) begin
      wait_cyc <= 4'(i * 3);
      xfer(30'h1000 + 30'(i), 4'hF, st[i]);
    end
    wait_cyc <= 4'h0;
    $display("done: cycle types and waits");
  endtask
  task automatic t_lanes();
    logic [3:0] be [6] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'hC, 4'h6};
    for (int i = 0; i < 6; i++) xfer(30'h3FFFFFFF - 30'(i), be[i], 4'hE);
    $display("done: byte lanes");
  endtask
  task automatic t_narrow();
    logic [3:0] be [3] = '{4'hF, 4'hC, 4'h3};
    int s0;
    @(posedge core_clk);
    half_width_bus_n <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      s0 = strobes;
      xfer(30'h2AAA + 30'(i), be[i], 4'h6);
      check(32'(strobes - s0), (i == 0) ? 32'h2 : 32'h1, "narrow cycles");
    end
    @(posedge core_clk);
    half_width_bus_n <= 1'b1;
    $display("done: narrow bus");
  endtask
  task automatic t_hold();
    int n = 0;
    @(posedge core_clk);
    hold_req <= 1'b1;
    do @(negedge core_clk); while (bus_release_grant !== 1'b1 && ++n < 100);
    check({31'h0, bus_oe_n}, 32'h1, "bus released");
    @(posedge core_clk);
    hold_req <= 1'b0;
    do @(negedge core_clk); while (bus_release_grant !== 1'b0 && ++n < 200);
    check({31'h0, bus_oe_n}, 32'h0, "bus taken back");
    xfer(30'h55, 4'hF, 4'h6);
    $display("done: hold");
  endtask
  task automatic t_pins(input logic on);
    int ev = 0;
    logic [3:0] side;
    @(posedge core_clk);
    maskable_irq <= on;
    nmi <= on;
    busy_n <= !on;
    error_n <= !on;
    coproc_xfer_request <= on;
    repeat (8) @(negedge core_clk) ev += int'(nmi_event === 1'b1);
    side = {int_request, coproc_busy, coproc_fault, coproc_want_xfer};
    check({28'h0, side}, {28'h0, {4{on}}}, "pins");
    check(32'(ev), {31'h0, on}, "nmi pulse");
    $display("done: side pins %0d", on);
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    check({28'h0, addr_valid_strobe_n, bus_release_grant, data_lines_oe_n, rsp_valid}, 32'hA, "reset");
    @(posedge core_clk);
    nrst <= 1'b1;
    t_types();
    t_lanes();
    t_narrow();
    t_hold();
    t_pins(1'b1);
    t_pins(1'b0);
    test_done();
  end
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule

/* rtl/lbi_local_bus.sv */
`timescale 1ns/100ps
module lbi_local_bus
  import lbi_pkg::*;
#(
  parameter int DATA_W = LBI_DATA_W,
  parameter int ADDR_W = LBI_ADDR_W
) (
  input  wire logic              core_clk,             // Double rate clock
  input  wire logic              nrst,                 // Sync reset, low
  // Core request side
  input  wire logic              req_valid,            // Transfer request
  output logic                   req_ready,            // Request taken this cycle
  input  wire logic [ADDR_W-1:0] req_addr,             // Word address
  input  wire logic [3:0]        req_be,               // Lanes, active high
  input  wire logic              req_write,            // Write cycle
  input  wire logic              req_mem,              // Memory cycle
  input  wire logic              req_data,             // Data cycle
  input  wire logic              req_lock,             // Locked cycle
  input  wire logic [DATA_W-1:0] req_wdata,            // Write data
  output logic                   rsp_valid,            // Cycle done pulse
  output logic [DATA_W-1:0]      rsp_rdata,            // Read data
  output logic                   int_request,          // Maskable irq level
  output logic                   nmi_event,            // Nmi rising edge pulse
  output logic                   coproc_busy,          // Coprocessor occupied
  output logic                   coproc_fault,         // Coprocessor fault
  output logic                   coproc_want_xfer,     // Coprocessor wants data
  output logic                   proc_phase,           // Internal clock phase
  // Bus pins
  input  wire logic [DATA_W-1:0] data_lines_in,        // Data in
  output logic [DATA_W-1:0]      data_lines_out,       // Data out
  output logic                   data_lines_oe_n,      // Data drive, low on
  output logic [ADDR_W-1:0]      word_address,         // Address lines
  output logic [3:0]             byte_lane_en_n,       // Byte lanes, low
  output logic                   addr_valid_strobe_n,  // Address strobe
  output logic                   write_read,           // High for write
  output logic                   mem_io,               // High for memory
  output logic                   data_ctrl,            // High for data
  output logic                   lock_n,               // Locked cycle, low
  output logic                   bus_oe_n,             // Address/status drive
  input  wire logic              ready_n,              // Cycle completion
  input  wire logic              next_addr_req_n,      // Pipeline request
  input  wire logic              half_width_bus_n,     // 16-bit target
  input  wire logic              hold_req,             // Bus hold request
  output logic                   bus_release_grant,    // Hold acknowledge
  input  wire logic              maskable_irq,         // Maskable interrupt
  input  wire logic              nmi,                  // Non-maskable int
  input  wire logic              busy_n,               // Coproc busy
  input  wire logic              error_n,              // Coproc error
  input  wire logic              coproc_xfer_request   // Coproc request
);

  if (DATA_W != LBI_DATA_W || ADDR_W != LBI_ADDR_W) begin : g_bad
    $error("lbi_local_bus serves only 32 data and 30 address lines");
  end

  // ==========================================================
  // Input synchronisers
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  assign pin_raw = {ready_n, next_addr_req_n, half_width_bus_n, hold_req,
                    maskable_irq, nmi, busy_n, error_n, coproc_xfer_request};

  // Bits land on every rising edge; timing of the pins is not trusted
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      // Idle levels, so no false coprocessor request follows reset
      sync1 <= {1'b1, 1'b1, 1'b1, 6'h06};
      sync2 <= {1'b1, 1'b1, 1'b1, 6'h06};
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end

  logic rdy_s, na_s, half_width_bus_n_s, hold_s;
  assign rdy_s  = ~sync2[8];
  assign na_s   = ~sync2[7];
  assign half_width_bus_n_s = ~sync2[6];
  assign hold_s = sync2[5];

  // ==========================================================
  // Side pins toward the core
  logic nmi_last;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      int_request      <= 1'b0;
      nmi_event        <= 1'b0;
      nmi_last         <= 1'b0;
      coproc_busy      <= 1'b0;
      coproc_fault     <= 1'b0;
      coproc_want_xfer <= 1'b0;
    end else begin
      int_request      <= sync2[4];
      nmi_last         <= sync2[3];
      nmi_event        <= sync2[3] & ~nmi_last;
      coproc_busy      <= ~sync2[2];
      coproc_fault     <= ~sync2[1];
      coproc_want_xfer <= sync2[0];
    end
  end

  // ==========================================================
  // Internal clock phase
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      proc_phase <= LBI_PH_RESET;
    end else begin
      proc_phase <= ~proc_phase;
    end
  end

  // ==========================================================
  // Bus cycle sequencer
  // Decisions happen only at the end of a processor clock (phase high).
  lbi_state_t        state;
  logic              hold_smp;
  logic              pipe_valid;
  logic              split;
  logic              cur_write;
  logic [DATA_W-1:0] cur_wdata;
  logic [3:0]        cur_be;
  logic [ADDR_W-1:0] cur_addr;
  logic              take;
  logic              wide_hi;
  logic              wide_lo;

  assign take    = req_valid & req_ready;
  assign wide_hi = |(cur_be & LBI_HI_LANES);
  assign wide_lo = |(cur_be & LBI_LOW_LANES);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hold_smp  <= 1'b0;
      req_ready <= 1'b0;
    end else if (!proc_phase) begin
      hold_smp  <= hold_s;
      // Open for one cycle, aligned to the deciding edge
      // No pipelining behind a narrow target: the split needs the current lanes
      req_ready <= (state == LBI_IDLE && !hold_s) ||
                   (state == LBI_WAIT && na_s && !half_width_bus_n_s && !pipe_valid && !split);
    end else begin
      req_ready <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state               <= LBI_IDLE;
      pipe_valid          <= 1'b0;
      split               <= 1'b0;
      cur_write           <= 1'b0;
      cur_wdata           <= '0;
      cur_be              <= LBI_BE_IDLE;
      cur_addr            <= '0;
      word_address        <= '0;
      byte_lane_en_n      <= LBI_BE_IDLE;
      addr_valid_strobe_n <= 1'b1;
      write_read          <= 1'b0;
      mem_io              <= 1'b0;
      data_ctrl           <= 1'b0;
      lock_n              <= 1'b1;
      bus_oe_n            <= 1'b0;
      bus_release_grant   <= 1'b0;
      data_lines_oe_n     <= 1'b1;
      data_lines_out      <= '0;
      rsp_valid           <= 1'b0;
      rsp_rdata           <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (proc_phase) begin
        if (take) begin
          // Address and status out with the strobe
          word_address        <= req_addr;
          byte_lane_en_n      <= ~req_be;
          write_read          <= req_write;
          mem_io              <= req_mem;
          data_ctrl           <= req_data;
          lock_n              <= ~req_lock;
          addr_valid_strobe_n <= 1'b0;
        end else begin
          addr_valid_strobe_n <= 1'b1;
        end
        unique case (state)
          LBI_IDLE: begin
            if (take) begin
              state     <= LBI_ADDR;
              cur_write <= req_write;
              cur_wdata <= req_wdata;
              cur_be    <= req_be;
              cur_addr  <= req_addr;
            end else if (hold_smp) begin
              state             <= LBI_HELD;
              bus_oe_n          <= 1'b1;
              bus_release_grant <= 1'b1;
            end
          end
          LBI_ADDR: begin
            state           <= LBI_WAIT;
            data_lines_oe_n <= ~cur_write;
            data_lines_out  <= cur_wdata;
          end
          LBI_WAIT: begin
            if (take) begin
              pipe_valid <= 1'b1;
            end
            if (rdy_s) begin
              if (split) begin
                rsp_rdata[DATA_W-1:LBI_HALF_W] <= data_lines_in[LBI_HALF_W-1:0];
              end else begin
                rsp_rdata <= data_lines_in;
              end
              if (half_width_bus_n_s && !split && wide_hi && wide_lo) begin
                // Narrow target: extra cycle moves the upper half
                split               <= 1'b1;
                cur_be              <= cur_be & LBI_HI_LANES;
                byte_lane_en_n      <= ~(cur_be & LBI_HI_LANES);
                word_address        <= cur_addr;
                addr_valid_strobe_n <= 1'b0;
                data_lines_out      <= {cur_wdata[DATA_W-1:LBI_HALF_W],
                                        cur_wdata[DATA_W-1:LBI_HALF_W]};
                state               <= LBI_ADDR;
              end else begin
                split           <= 1'b0;
                rsp_valid       <= 1'b1;
                data_lines_oe_n <= 1'b1;
                if (half_width_bus_n_s && !split && wide_hi) begin
                  // Upper lanes only: data came on the low lines
                  rsp_rdata[DATA_W-1:LBI_HALF_W] <= data_lines_in[LBI_HALF_W-1:0];
                end
                if (pipe_valid || take) begin
                  pipe_valid <= 1'b0;
                  state      <= LBI_ADDR;
                end else begin
                  state <= LBI_IDLE;
                end
              end
            end
            if (take) begin
              // Held until the old cycle drains
              cur_write <= req_write;
              cur_wdata <= req_wdata;
              cur_be    <= req_be;
              cur_addr  <= req_addr;
            end
          end
          LBI_HELD: begin
            if (!hold_smp) begin
              state             <= LBI_IDLE;
              bus_oe_n          <= 1'b0;
              bus_release_grant <= 1'b0;
            end
          end
        endcase
      end
    end
  end

endmodule

/* rtl/lbi_pkg.sv */
// ==========================================================
// Local bus interface constants
package lbi_pkg;
  localparam int          LBI_DATA_W    = 32;  // Data lines
  localparam int          LBI_ADDR_W    = 30;  // Word address lines
  localparam int          LBI_BE_W      = 4;   // Byte lanes
  localparam int          LBI_HALF_W    = 16;  // Narrow bus width
  localparam int          LBI_CLK_DIV   = 2;   // Internal clock divide
  localparam int          LBI_SYNC_LEN  = 2;   // Pin synchroniser depth
  localparam logic [3:0]  LBI_LOW_LANES = 4'h3;
  localparam logic [3:0]  LBI_HI_LANES  = 4'hC;
  localparam logic [3:0]  LBI_BE_IDLE   = 4'hF;
  localparam logic        LBI_PH_RESET  = 1'b0;

  typedef enum logic [1:0] {
    LBI_IDLE,
    LBI_ADDR,
    LBI_WAIT,
    LBI_HELD
  } lbi_state_t;
endpackage
